// file: logic/pog_pkg.sv
package pog_pkg;

  // Register offsets, printed values are not all multiples of four,
  // so each is an index and the byte address is four times it
  localparam logic [7:0] PORT_A_OUTPUT_LATCH_PIN_IDX = 8'h00;
  localparam logic [7:0] PORT_A_OUTPUT_LATCH_DIR_IDX = 8'h01;
  localparam logic [7:0] PORT_A_OUTPUT_LATCH_LAT_IDX = 8'h02;
  localparam logic [7:0] PORT_B_OUTPUT_LATCH_PIN_IDX = 8'h03;
  localparam logic [7:0] PORT_B_OUTPUT_LATCH_DIR_IDX = 8'h04;
  localparam logic [7:0] PORT_B_OUTPUT_LATCH_LAT_IDX = 8'h05;
  localparam logic [7:0] PORT_C_OUTPUT_LATCH_PIN_IDX = 8'h06;
  localparam logic [7:0] PORT_C_OUTPUT_LATCH_DIR_IDX = 8'h07;
  localparam logic [7:0] PORT_C_OUTPUT_LATCH_LAT_IDX = 8'h08;
  localparam logic [7:0] PORTD_PIN_IDX = 8'h09;
  localparam logic [7:0] PORTD_DIR_IDX = 8'h0A;
  localparam logic [7:0] PORTD_LAT_IDX = 8'h0B;
  localparam logic [7:0] CHIP_CTRL_IDX = 8'h35;
  // Peripheral enable register of this block's own
  localparam logic [7:0] PERIPH_EN_IDX = 8'h40;

  // Reset values
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [7:0] CHIP_CTRL_RESET = 8'h00;
  localparam logic [7:0] PERIPH_EN_RESET = 8'h00;

  // Chip control fields
  localparam int PULLUP_OFF_BIT = 4;
  // Writable chip control bits: 7, 4, 1, 0
  localparam logic [7:0] CHIP_CTRL_WMASK = 8'h93;

  // Peripheral enable fields
  localparam int PE_TX0 = 0;
  localparam int PE_RX0 = 1;
  localparam int PE_TX1 = 2;
  localparam int PE_RX1 = 3;
  localparam int PE_PCG = 4;

  // Pin override bundle for one pin
  typedef struct packed {
    logic pullup_override_enable;
    logic pullup_override_value;
    logic direction_override_enable;
    logic direction_override_value;
    logic pin_value_override_enable;
    logic pin_value_override_value;
    logic input_enable_override_enable;
    logic input_enable_override_value;
  } pog_ovr_t;

  // Peripheral signals toward port D
  typedef struct packed {
    logic serial0_transmit_line;
    logic serial1_transmit_line;
    logic timer2_compare_a_out;
    logic timer2_compare_a_en;
    logic timer2_compare_b_out;
    logic timer2_compare_b_en;
    logic timer1_compare_a_out;
    logic timer1_compare_a_en;
    logic timer1_compare_b_out;
    logic timer1_compare_b_en;
    logic [7:0] pin_change_select;
  } pog_periph_t;

endpackage : pog_pkg

// file: logic/pog_top.sv
// Chosen here: register access over APB.
`timescale 1ns/1ps
// Overview of operation
// - Transmitter 0 drives port D bit 1
// - Receiver 0 forces port D bit 0 input
// - Forced input keeps latch-driven pull-up
// - Bit 1 feeds pin-change source 25
// - Bit 0 feeds pin-change source 24
// - Bits 7-4: compare outputs replace pin value
// - Bit 3 transmit override, bit 2 receive input
// - Global pull-up off disables all pull-ups
// - Chip control: bit 4 pull-up off, masks
// - Port A registers at 0x00-0x02
// - Port B registers at 0x03-0x05
// - Port C registers at 0x06-0x08
// - Port D registers at 0x09-0x0B
module pog_top
  import pog_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Peripheral side
  input wire pog_periph_t periph_i,
  output logic serial0_receive_line_o,
  output logic serial1_receive_line_o,
  output logic timer1_capture_in_o,
  output logic external_irq_zero_o,
  output logic external_irq_one_o,
  output logic [7:0] pin_change_d_o,
  // Pins, ports A to D
  input wire logic [31:0] pin_i,
  output logic [31:0] pin_o,
  output logic [31:0] pin_oe_o,
  output logic [31:0] pin_pullup_o
);

  // Registers
  logic [7:0] dir [4];
  logic [7:0] lat [4];
  logic [7:0] chip_control;
  logic [7:0] periph_en;
  logic [31:0] sync1;
  logic [31:0] sync2;
  pog_ovr_t ovr [32];
  logic [31:0] in_en;
  logic [31:0] eff_dir;
  logic [31:0] pin_in;
  logic global_pullup_off;

  // Bus decode
  logic acc;
  logic [9:0] idx;
  logic [7:0] rd_val;
  logic hit;

  // Bus strobes and the always-ready handshake; upper index bits
  // must be zero, else the access counts as unmapped
  assign acc = psel_i && penable_i;
  assign idx = paddr_i[11:2];
  assign pready_o = 1'b1;
  assign global_pullup_off = chip_control[PULLUP_OFF_BIT];

  // Pin synchroniser, two stages; pins are asynchronous to the
  // core clock, so both stages settle before any logic reads them
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1 <= 32'h0000_0000;
      sync2 <= 32'h0000_0000;
    end else begin
      sync1 <= pin_i;
      sync2 <= sync1;
    end
  end

  // Digital input gating after synchroniser
  assign pin_in = sync2 & in_en;

  // Read decode
  always_comb begin
    rd_val = 8'h00;
    hit = 1'b1;
    if (idx[9:8] != 2'b00) begin
      hit = 1'b0;
    end else if (idx[7:0] == PORT_A_OUTPUT_LATCH_PIN_IDX) begin
      rd_val = pin_in[7:0];
    end else if (idx[7:0] == PORT_A_OUTPUT_LATCH_DIR_IDX) begin
      rd_val = dir[0];
    end else if (idx[7:0] == PORT_A_OUTPUT_LATCH_LAT_IDX) begin
      rd_val = lat[0];
    end else if (idx[7:0] == PORT_B_OUTPUT_LATCH_PIN_IDX) begin
      rd_val = pin_in[15:8];
    end else if (idx[7:0] == PORT_B_OUTPUT_LATCH_DIR_IDX) begin
      rd_val = dir[1];
    end else if (idx[7:0] == PORT_B_OUTPUT_LATCH_LAT_IDX) begin
      rd_val = lat[1];
    end else if (idx[7:0] == PORT_C_OUTPUT_LATCH_PIN_IDX) begin
      rd_val = pin_in[23:16];
    end else if (idx[7:0] == PORT_C_OUTPUT_LATCH_DIR_IDX) begin
      rd_val = dir[2];
    end else if (idx[7:0] == PORT_C_OUTPUT_LATCH_LAT_IDX) begin
      rd_val = lat[2];
    end else if (idx[7:0] == PORTD_PIN_IDX) begin
      rd_val = pin_in[31:24];
    end else if (idx[7:0] == PORTD_DIR_IDX) begin
      rd_val = dir[3];
    end else if (idx[7:0] == PORTD_LAT_IDX) begin
      rd_val = lat[3];
    end else if (idx[7:0] == CHIP_CTRL_IDX) begin
      rd_val = chip_control;
    end else if (idx[7:0] == PERIPH_EN_IDX) begin
      rd_val = periph_en;
    end else begin
      hit = 1'b0;
    end
  end

  // Error for unmapped address; such writes are dropped
  // and such reads return zero
  assign pslverr_o = acc && !hit;

  // Read data register: loaded at the setup edge so that it
  // already stands when the access edge samples pready; it holds
  // until the next read setup, writes leave it untouched
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= {24'h00_0000, rd_val};
    end
  end

  // Port direction and latch registers; a write to the pin
  // register toggles the latch bits written as one
  // Toggling saves software a read-modify-write on the latch
  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_port
      logic [7:0] a_pin;
      logic [7:0] a_dir;
      logic [7:0] a_lat;
      assign a_pin = PORT_A_OUTPUT_LATCH_PIN_IDX + 8'(3 * p);
      assign a_dir = PORT_A_OUTPUT_LATCH_DIR_IDX + 8'(3 * p);
      assign a_lat = PORT_A_OUTPUT_LATCH_LAT_IDX + 8'(3 * p);
      // Direction and latch reset to zero
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          dir[p] <= PORT_RESET;
          lat[p] <= PORT_RESET;
        end else if (acc && pwrite_i && idx[9:8] == 2'b00) begin
          if (idx[7:0] == a_dir) begin
            dir[p] <= pwdata_i[7:0];
          end else if (idx[7:0] == a_lat) begin
            lat[p] <= pwdata_i[7:0];
          end else if (idx[7:0] == a_pin) begin
            lat[p] <= lat[p] ^ pwdata_i[7:0];
          end
        end
      end
    end
  endgenerate

  // Chip control with read-only bits held at zero
  // Bits 6, 5, 3 and 2 are never stored, so they read as zero
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      chip_control <= CHIP_CTRL_RESET;
    end else if (acc && pwrite_i && idx == {2'b00, CHIP_CTRL_IDX}) begin
      chip_control <= pwdata_i[7:0] & CHIP_CTRL_WMASK;
    end
  end

  // Peripheral enables written by software; this register stands
  // in for the serial and pin-change units outside this block
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      periph_en <= PERIPH_EN_RESET;
    end else if (acc && pwrite_i && idx == {2'b00, PERIPH_EN_IDX}) begin
      periph_en <= pwdata_i[7:0];
    end
  end

  // Override table: ports A-C have none
  logic tx0;
  logic rx0;
  logic tx1;
  logic rx1;
  logic pcg;
  assign tx0 = periph_en[PE_TX0];
  assign rx0 = periph_en[PE_RX0];
  assign tx1 = periph_en[PE_TX1];
  assign rx1 = periph_en[PE_RX1];
  assign pcg = periph_en[PE_PCG];

  // Cleared first so that every field has a value on every path
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      ovr[i] = '0;
    end
    // Bit 0 pin change 24; receiver forces input
    ovr[24].pullup_override_enable = rx0;
    // Pull-up still from latch, gated by global off
    ovr[24].pullup_override_value = lat[3][0] & ~global_pullup_off;
    ovr[24].direction_override_enable = rx0;
    ovr[24].direction_override_value = 1'b0;
    ovr[24].input_enable_override_enable =
      periph_i.pin_change_select[0] & pcg;
    ovr[24].input_enable_override_value = 1'b1;
    // Transmitter 0 drives bit 1; pin change 25
    ovr[25].pullup_override_enable = tx0;
    ovr[25].direction_override_enable = tx0;
    ovr[25].direction_override_value = 1'b1;
    ovr[25].pin_value_override_enable = tx0;
    ovr[25].pin_value_override_value = periph_i.serial0_transmit_line;
    ovr[25].input_enable_override_enable =
      periph_i.pin_change_select[1] & pcg;
    ovr[25].input_enable_override_value = 1'b1;
    // Receiver 1 forces bit 2 input
    ovr[26].pullup_override_enable = rx1;
    ovr[26].pullup_override_value = lat[3][2] & ~global_pullup_off;
    ovr[26].direction_override_enable = rx1;
    ovr[26].input_enable_override_enable =
      periph_i.pin_change_select[2] & pcg;
    ovr[26].input_enable_override_value = 1'b1;
    ovr[27].pullup_override_enable = tx1;
    ovr[27].direction_override_enable = tx1;
    ovr[27].direction_override_value = 1'b1;
    ovr[27].pin_value_override_enable = tx1;
    ovr[27].pin_value_override_value = periph_i.serial1_transmit_line;
    ovr[27].input_enable_override_enable =
      periph_i.pin_change_select[3] & pcg;
    ovr[27].input_enable_override_value = 1'b1;
    // Compare outputs replace pin value on bits 7-4
    ovr[28].pin_value_override_enable = periph_i.timer1_compare_b_en;
    ovr[28].pin_value_override_value = periph_i.timer1_compare_b_out;
    ovr[29].pin_value_override_enable = periph_i.timer1_compare_a_en;
    ovr[29].pin_value_override_value = periph_i.timer1_compare_a_out;
    ovr[30].pin_value_override_enable = periph_i.timer2_compare_b_en;
    ovr[30].pin_value_override_value = periph_i.timer2_compare_b_out;
    ovr[31].pin_value_override_enable = periph_i.timer2_compare_a_en;
    ovr[31].pin_value_override_value = periph_i.timer2_compare_a_out;
    for (int i = 28; i < 32; i++) begin
      ovr[i].input_enable_override_enable =
        periph_i.pin_change_select[i - 24] & pcg;
      ovr[i].input_enable_override_value = 1'b1;
    end
  end

  // Per-pin selection of register or override values
  genvar b;
  generate
    for (b = 0; b < 32; b++) begin : g_pin
      logic r_dir;
      logic r_lat;
      assign r_dir = dir[b / 8][b % 8];
      assign r_lat = lat[b / 8][b % 8];
      assign eff_dir[b] = ovr[b].direction_override_enable ?
        ovr[b].direction_override_value : r_dir;
      assign pin_oe_o[b] = eff_dir[b];
      assign pin_o[b] = ovr[b].pin_value_override_enable ?
        ovr[b].pin_value_override_value : r_lat;
      // Pull-up only for input, latch one, not off
      // A pull-up never meets a driven pin: an output clears it
      assign pin_pullup_o[b] = ovr[b].pullup_override_enable ?
        ovr[b].pullup_override_value :
        (~eff_dir[b] & r_lat & ~global_pullup_off);
      // Digital input enable, on unless overridden off
      // No sleep gating here, so the input stays on by default
      assign in_en[b] = ovr[b].input_enable_override_enable ?
        ovr[b].input_enable_override_value : 1'b1;
    end
  endgenerate

  // Peripheral inputs from port D
  // All taken after the synchroniser and the input enable
  assign serial0_receive_line_o = pin_in[24];
  assign serial1_receive_line_o = pin_in[26];
  assign external_irq_zero_o = pin_in[26];
  assign external_irq_one_o = pin_in[27];
  assign timer1_capture_in_o = pin_in[30];
  assign pin_change_d_o = pin_in[31:24];

endmodule : pog_top

// file: testbench/pog_pins_model.sv
`timescale 1ns/1ps
module pog_pins_model (
  // Design side of each pin
  input wire logic [31:0] drv_i,
  input wire logic [31:0] oe_i,
  // Outside circuit level
  input wire logic [31:0] ext_i,
  // Resolved wire level
  output logic [31:0] lvl_o
);
  // Outside circuit yields wherever the port drives
  assign lvl_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule : pog_pins_model

// file: testbench/pog_top_assertions.sv
`timescale 1ns/1ps
module pog_top_chk
  import pog_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Peripheral and pins
  input wire pog_periph_t periph_i,
  input wire logic [31:0] pin_o,
  input wire logic [31:0] pin_oe_o,
  input wire logic [31:0] pin_pullup_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic acc;
  logic wr;
  logic unm;
  logic [7:0] ix;
  // Access decode, unmapped when past port D except chip control and peripheral enable, or upper address bits set
  assign acc = psel_i & penable_i;
  assign wr = acc & pwrite_i;
  assign ix = paddr_i[9:2];
  assign unm = (paddr_i[11:10] != 2'b00) || (ix > PORTD_LAT_IDX &&
    ix != CHIP_CTRL_IDX && ix != PERIPH_EN_IDX);
  bus_ready_a: assert property (psel_i |-> pready_o)
    else $error("ready missing");
  unmapped_err_a: assert property (acc |-> pslverr_o == unm)
    else $error("error response wrong");
  upper_zero_a: assert property (acc && !pwrite_i |=>
    prdata_o[31:8] == 24'h0) else $error("upper read bits set");
  pullup_off_a: assert property (wr && !unm &&
    ix == CHIP_CTRL_IDX && pwdata_i[PULLUP_OFF_BIT] |=>
    pin_pullup_o == 32'h0) else $error("pull-up left on");
  pullup_dir_a: assert property ((pin_pullup_o & pin_oe_o) == 0)
    else $error("pull-up on driven pin");
  tx0_drive_a: assert property (wr && !unm &&
    ix == PERIPH_EN_IDX &&
    pwdata_i[PE_TX0] |=> pin_oe_o[25] &&
    pin_o[25] == periph_i.serial0_transmit_line)
    else $error("transmit 0 not driven");
  rx0_input_a: assert property (wr && !unm &&
    ix == PERIPH_EN_IDX &&
    pwdata_i[PE_RX0] |=> !pin_oe_o[24]) else $error("receive 0 driven");
  tx1_drive_a: assert property (wr && !unm &&
    ix == PERIPH_EN_IDX &&
    pwdata_i[PE_TX1] |=> pin_oe_o[27] && !pin_pullup_o[27] &&
    pin_o[27] == periph_i.serial1_transmit_line)
    else $error("transmit 1 not driven");
  cmp_value_a: assert property (periph_i.timer2_compare_a_en |->
    pin_o[31] == periph_i.timer2_compare_a_out)
    else $error("compare value lost");
  // Main scenarios
  cover property (wr && ix == CHIP_CTRL_IDX);
  cover property (wr && ix == PERIPH_EN_IDX);
  cover property (acc && pslverr_o);
endmodule : pog_top_chk
bind pog_top pog_top_chk i_pog_top_chk (.core_clk_i(core_clk_i),
  .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .periph_i(periph_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
  .pin_pullup_o(pin_pullup_o));

// file: testbench/pog_top_tb.sv
`timescale 1ns/1ps
module pog_top_tb;
  import pog_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic psel = 0;
  logic pen = 0;
  logic pwr = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, pin, po, poe, ppu;
  logic [31:0] ext = 32'hA53C_96E1;
  logic rdy, serr, se, r0, r1, cap, i0, i1;
  logic [7:0] pcd, rd;
  pog_periph_t per = '0;
  int err_count = 0;
  int samples_checked = 0;
  // Clock at 125 MHz
  always #4 clk = ~clk;
  pog_top i_pog_top (.core_clk_i(clk), .rst_i(rst), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(rdy),
    .pslverr_o(serr), .periph_i(per), .serial0_receive_line_o(r0),
    .serial1_receive_line_o(r1), .timer1_capture_in_o(cap),
    .external_irq_zero_o(i0), .external_irq_one_o(i1),
    .pin_change_d_o(pcd), .pin_i(pin), .pin_o(po), .pin_oe_o(poe),
    .pin_pullup_o(ppu));
  pog_pins_model i_pog_pins_model (.drv_i(po), .oe_i(poe),
    .ext_i(ext), .lvl_o(pin));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One bus transfer, read data and error taken at the access edge
  task automatic apb(input logic w, input logic [7:0] ix,
    input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {2'b00, ix, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    se = serr;
    rd = prdata[7:0];
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    complete_run();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int p = 0; p < 4; p++) begin
      apb(1'b0, 8'(3 * p + 1), 8'h00);
      chk(rd, 32'h0);
      apb(1'b0, 8'(3 * p + 2), 8'h00);
      chk(rd, 32'h0);
      apb(1'b1, 8'(3 * p + 1), 8'h0F);
      apb(1'b1, 8'(3 * p + 2), 8'h35);
      apb(1'b0, 8'(3 * p + 1), 8'h00);
      chk(rd, 32'h0F);
      apb(1'b0, 8'(3 * p + 2), 8'h00);
      chk(rd, 32'h35);
      apb(1'b0, 8'(3 * p), 8'h00);
      chk(rd, 8'h05 | (8'hF0 & ext[8 * p +: 8]));
      chk(poe[8 * p +: 8], 32'h0F);
      chk(po[8 * p +: 8] & 8'h0F, 32'h05);
      chk(ppu[8 * p +: 8], 32'h30);
    end
    apb(1'b0, CHIP_CTRL_IDX, 8'h00);
    chk(rd, 32'h0);
    apb(1'b1, CHIP_CTRL_IDX, 8'hFF);
    apb(1'b0, CHIP_CTRL_IDX, 8'h00);
    chk(rd, 32'h93);
    chk(ppu, 32'h0);
    apb(1'b1, CHIP_CTRL_IDX, 8'h00);
    apb(1'b1, 8'h20, 8'hFF);
    chk(se, 32'h1);
    apb(1'b0, 8'h20, 8'h00);
    chk(rd, 32'h0);
    // Transmit 0 high, compare outputs 1010 enabled, all sources
    per <= pog_periph_t'(18'h2DDFF);
    apb(1'b1, PORTD_DIR_IDX, 8'h05);
    apb(1'b1, PERIPH_EN_IDX, 8'h1F);
    repeat (3) @(posedge clk);
    chk(poe[31:24], 32'h0A);
    chk({po[27], po[25]}, 32'h1);
    chk(ppu[27:24], 32'h5);
    chk(po[31:28], 32'hA);
    chk(pcd[1:0], 32'h3);
    chk(r0, ext[24]);
    chk(cap, ext[30]);
    chk(r1, ext[26]);
    chk(i0, ext[26]);
    chk(i1, 1'b0);
    chk(pcd, {ext[31:28], 1'b0, ext[26], 1'b1, ext[24]});
    complete_run();
  end
endmodule : pog_top_tb
